// >>> logic/relay_scanner_command_control.sv
// Relay scanner card command control with APB register access
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module relay_scanner_command_control #(
    parameter int CYC_PER_MS = scan_pkg::CYC_PER_MS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // APB slave
    input wire logic [scan_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Card presence pin
    input wire logic card_present,
    // Relay drive
    output logic [scan_pkg::CHANNELS-1:0] relay_close,
    output logic [scan_pkg::CHANNELS-1:0] short_en,
    output logic vsrc_limit_200,
    // Scan progress
    output logic scan_active,
    output logic scan_done,
    output logic read_take,
    output logic store_take,
    output logic [scan_pkg::CNT_W-1:0] store_index
);
    import scan_pkg::*;

    typedef struct packed {
        logic card_s1;
        logic card_s2;
        logic ready;
        logic slverr;
        logic [31:0] rdata;
        logic [CHANNELS-1:0] relay;
        logic [CHANNELS-1:0] shorts;
        logic [CHANNELS-1:0] list;
        logic [EXT_W-1:0] ext;
        logic [1:0] sel;
        logic [SETTLE_W-1:0] settle;
        logic current;
        logic vlimit;
        logic [CNT_W-1:0] count;
        logic [MS_W-1:0] interval;
        logic timer_en;
        logic store_en;
        scan_state_type st;
        logic [3:0] ch;
        logic [CNT_W-1:0] passes;
        logic [CNT_W-1:0] idx;
        logic active;
        logic done;
        logic aborted;
        logic err_range;
        logic err_hw;
        logic read_pulse;
        logic store_pulse;
        logic tstart;
        logic [MS_W-1:0] tload;
    } state_type;

    state_type q, d;
    logic card, prep, commit, mapped, rej_range, rej_hw;
    logic do_start, do_abort;
    logic [31:0] rd;
    logic [3:0] wch;
    logic [1:0] wop;
    logic [4:0] nxt, first;

    if (CYC_PER_MS < 1) begin : g_bad_rate
        $error("CYC_PER_MS must be at least 1");
    end

    // Lowest listed channel at or above a start index, with a found bit
    function automatic logic [4:0] next_ch(input logic [CHANNELS-1:0] l,
                                           input logic [3:0] from);
        logic [4:0] r;
        r = 5'h00;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (l[i] && 4'(i) >= from) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    // Number of channels in a list
    function automatic logic [3:0] ones(input logic [CHANNELS-1:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < CHANNELS; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    // Settling and pacing share one timer; they never overlap
    timer_if tif ();
    assign tif.start = q.tstart;
    assign tif.load_ms = q.tload;

    ms_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .tmr(tif)
    );

    // Address decode, read mux and write checks
    always_comb begin
        card = q.card_s2;
        wch = pwdata[CMD_CH_LSB +: 4];
        wop = pwdata[CMD_OP_LSB +: 2];
        mapped = 1'b1;
        rej_range = 1'b0;
        rej_hw = 1'b0;
        rd = 32'h0000_0000;
        case (paddr)
            ADDR_CHAN_CMD: begin
                rej_hw = !card;
                if ((wop == OP_CLOSE || wop == OP_OPEN) &&
                    (wch < CH_MIN || wch > CH_MAX)) begin
                    rej_range = 1'b1;
                end
            end
            ADDR_CHAN_STATE: rd[CHANNELS-1:0] = q.relay;
            ADDR_SCAN_LIST: begin
                rd[CHANNELS-1:0] = q.list;
                rej_range = ones(pwdata[CHANNELS-1:0]) < LIST_MIN;
            end
            ADDR_EXT_COUNT: begin
                rd[EXT_W-1:0] = q.ext;
                rej_range = pwdata < EXT_MIN || pwdata > EXT_MAX;
            end
            ADDR_LIST_SEL: begin
                rd[1:0] = q.sel;
                rej_range = pwdata[1:0] == SEL_BAD;
                rej_hw = pwdata[1:0] == SEL_INT && !card;
            end
            ADDR_SETTLE: begin
                rd[SETTLE_W-1:0] = q.settle;
                rej_hw = !card;
                rej_range = pwdata > SETTLE_MAX;
            end
            ADDR_METHOD: begin
                rd[0] = q.current;
                rej_hw = !card;
            end
            ADDR_VLIMIT: begin
                rd[0] = q.vlimit;
                rej_hw = !card;
            end
            ADDR_SCAN_COUNT: rd[CNT_W-1:0] = q.count;
            ADDR_INTERVAL: rd[MS_W-1:0] = q.interval;
            ADDR_SCAN_CTRL: begin
                rd[CTRL_TIMER] = q.timer_en;
                rd[CTRL_STORE] = q.store_en;
            end
            ADDR_STATUS: begin
                rd[ST_ACTIVE] = q.active;
                rd[ST_DONE] = q.done;
                rd[ST_ABORTED] = q.aborted;
                rd[ST_ERR_RANGE] = q.err_range;
                rd[ST_ERR_HW] = q.err_hw;
                rd[ST_CARD] = card;
            end
            ADDR_STORE_IDX: rd[CNT_W-1:0] = q.idx;
            default: mapped = 1'b0;
        endcase
    end

    // Next-state logic: status clears first so that any set below wins
    always_comb begin
        d = q;
        do_start = 1'b0;
        do_abort = 1'b0;
        d.card_s1 = card_present;
        d.card_s2 = q.card_s1;
        d.read_pulse = 1'b0;
        d.store_pulse = 1'b0;
        d.tstart = 1'b0;
        prep = psel && penable && !q.ready;
        commit = psel && penable && q.ready && pwrite;
        d.ready = prep;
        d.slverr = prep && (!mapped || (pwrite && (rej_range || rej_hw)));
        d.rdata = (prep && !pwrite) ? rd : 32'h0000_0000;
        first = next_ch(q.list, 4'h0);
        nxt = next_ch(q.list, q.ch + 4'h1);

        if (commit && paddr == ADDR_STATUS) begin
            d.done = q.done & ~pwdata[ST_DONE];
            d.aborted = q.aborted & ~pwdata[ST_ABORTED];
            d.err_range = q.err_range & ~pwdata[ST_ERR_RANGE];
            d.err_hw = q.err_hw & ~pwdata[ST_ERR_HW];
        end

        // Scan sequencer
        unique case (q.st)
            S_IDLE, S_DONE: ;
            S_GAP: begin
                d.relay = '0;
                d.st = S_CLOSE;
            end
            S_CLOSE: begin
                d.relay = CH_ONE << q.ch;
                d.tstart = 1'b1;
                d.tload = MS_W'(q.settle);
                d.st = S_SETTLE;
            end
            // Pulse raised on entry to read, so the relay is still closed
            S_SETTLE: begin
                if (tif.done) begin
                    d.read_pulse = 1'b1;
                    if (q.store_en) begin
                        d.store_pulse = 1'b1;
                        d.idx = q.idx + CNT_W'(1);
                    end
                    d.st = S_READ;
                end
            end
            S_READ: begin
                if (nxt[4]) begin
                    d.ch = nxt[3:0];
                    d.st = q.current ? S_CLOSE : S_GAP;
                end else begin
                    d.ch = first[3:0];
                    if (q.passes <= CNT_W'(1)) begin
                        d.relay = '0;
                        d.active = 1'b0;
                        d.done = 1'b1;
                        d.st = S_DONE;
                    end else begin
                        d.passes = q.passes - CNT_W'(1);
                        if (q.timer_en) begin
                            d.tstart = 1'b1;
                            d.tload = q.interval;
                            d.st = S_PACE;
                        end else begin
                            d.st = q.current ? S_CLOSE : S_GAP;
                        end
                    end
                end
            end
            S_PACE: begin
                if (tif.done) begin
                    d.st = q.current ? S_CLOSE : S_GAP;
                end
            end
            default: d.st = S_IDLE;
        endcase

        // Refused writes only raise an error flag; a write to an unmapped address raises none
        if (commit && q.slverr) begin
            d.err_hw = q.err_hw | rej_hw;
            d.err_range = q.err_range | rej_range;
        end

        // Accepted register writes
        if (commit && !q.slverr) begin
            case (paddr)
                ADDR_CHAN_CMD: begin
                    case (wop)
                        OP_CLOSE: d.relay = CH_ONE << (wch - CH_MIN);
                        OP_OPEN: d.relay = q.relay &
                            ~(CH_ONE << (wch - CH_MIN));
                        OP_OPEN_ALL: d.relay = '0;
                        default: ;
                    endcase
                end
                ADDR_SCAN_LIST: d.list = pwdata[CHANNELS-1:0];
                ADDR_EXT_COUNT: d.ext = pwdata[EXT_W-1:0];
                ADDR_LIST_SEL: begin
                    d.sel = pwdata[1:0];
                    do_start = pwdata[1:0] == SEL_INT;
                    do_abort = pwdata[1:0] != SEL_INT && q.active;
                end
                ADDR_SETTLE: d.settle = pwdata[SETTLE_W-1:0];
                ADDR_METHOD: d.current = pwdata[0];
                ADDR_VLIMIT: d.vlimit = pwdata[0];
                ADDR_SCAN_COUNT: d.count = pwdata[CNT_W-1:0];
                ADDR_INTERVAL: d.interval = pwdata[MS_W-1:0];
                ADDR_SCAN_CTRL: begin
                    d.timer_en = pwdata[CTRL_TIMER];
                    d.store_en = pwdata[CTRL_STORE];
                    do_abort = pwdata[CTRL_ABORT] && q.active;
                    do_start = pwdata[CTRL_AGAIN] && q.st == S_DONE;
                    if (pwdata[CTRL_EXIT] && q.st == S_DONE) begin
                        d.st = S_IDLE;
                        d.sel = SEL_NONE;
                    end
                end
                default: ;
            endcase
        end

        // Abort opens the relay at once, whatever the sequencer wanted
        if (do_abort) begin
            d.relay = '0;
            d.active = 1'b0;
            d.aborted = 1'b1;
            d.sel = SEL_NONE;
            d.st = S_IDLE;
        end
        if (do_start) begin
            d.relay = '0;
            d.active = 1'b1;
            d.done = 1'b0;
            d.aborted = 1'b0;
            d.passes = q.count;
            d.idx = '0;
            d.ch = first[3:0];
            d.st = S_GAP;
        end
        d.shorts = d.current ? ~d.relay : '0;
    end

    // State register; reset opens every relay
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
            q.list <= LIST_RST;
            q.ext <= EXT_RST;
            q.count <= COUNT_RST;
            q.interval <= INTERVAL_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign prdata = q.rdata;
    assign pready = q.ready;
    assign pslverr = q.slverr;
    assign relay_close = q.relay;
    assign short_en = q.shorts;
    assign vsrc_limit_200 = q.vlimit;
    assign scan_active = q.active;
    assign scan_done = q.done;
    assign read_take = q.read_pulse;
    assign store_take = q.store_pulse;
    assign store_index = q.idx;

    // Checks on the relay, bus and sequencer behaviour
    logic wr_end;
    assign wr_end = psel && penable && pready && pwrite;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_one_relay_closed: assert property ($onehot0(relay_close))
        else $error("more than one relay closed");
    a_reset_all_open: assert property (disable iff (1'b0)
        !reset_n |=> relay_close == '0)
        else $error("relay closed after reset");
    a_state_readback: assert property (
        psel && penable && !pready && !pwrite && paddr == ADDR_CHAN_STATE
        |=> prdata[CHANNELS-1:0] == $past(relay_close))
        else $error("channel state read wrong");
    a_chan_range: assert property (
        wr_end && paddr == ADDR_CHAN_CMD &&
        pwdata[CMD_OP_LSB +: 2] == OP_CLOSE &&
        (pwdata[CMD_CH_LSB +: 4] > CH_MAX || pwdata[CMD_CH_LSB +: 4] == 4'h0)
        |-> pslverr)
        else $error("bad channel accepted");
    a_list_size: assert property (
        wr_end && paddr == ADDR_SCAN_LIST &&
        ones(pwdata[CHANNELS-1:0]) < LIST_MIN |-> pslverr)
        else $error("short scan list accepted");
    a_ext_range: assert property (
        wr_end && paddr == ADDR_EXT_COUNT && pwdata > EXT_MAX |-> pslverr)
        else $error("external count above range accepted");
    a_int_needs_card: assert property (
        wr_end && paddr == ADDR_LIST_SEL && pwdata[1:0] == SEL_INT &&
        !$past(q.card_s2) |-> pslverr)
        else $error("internal list taken without card");
    a_hw_missing: assert property (
        wr_end && paddr == ADDR_METHOD && !$past(q.card_s2) |=> q.err_hw)
        else $error("missing hardware not flagged");
    a_settle_hold: assert property (
        scan_active && $changed(relay_close) && relay_close != '0
        |-> !read_take [*3])
        else $error("reading taken before settling");
    a_break_first: assert property (
        scan_active && !q.current && $past(relay_close) != '0 &&
        relay_close != '0 |-> relay_close == $past(relay_close))
        else $error("voltage mode made before break");
    a_short_open: assert property (
        short_en == (q.current ? ~relay_close : '0))
        else $error("open channels not shorted in current mode");
    a_none_stops: assert property (
        wr_end && !pslverr && paddr == ADDR_LIST_SEL &&
        pwdata[1:0] == SEL_NONE |=> !scan_active && relay_close == '0)
        else $error("scan not stopped");
    a_start_scan: assert property (
        wr_end && !pslverr && paddr == ADDR_LIST_SEL &&
        pwdata[1:0] == SEL_INT |=> scan_active ##2 $onehot(relay_close))
        else $error("scan did not start");
    a_done_opens: assert property (
        $rose(scan_done) |-> relay_close == '0 && !scan_active)
        else $error("relay left closed at scan end");
endmodule

// >>> logic/scan_pkg.sv
// Shared constants and types for the relay scanner controller
package scan_pkg;
    // Card geometry and field widths
    localparam int CHANNELS = 10;
    localparam int ADDR_W = 8;
    localparam int MS_W = 24;
    localparam int EXT_W = 9;
    localparam int SETTLE_W = 20;
    localparam int CNT_W = 16;

    // Clock period and the millisecond tick derived from it
    localparam int CLK_PERIOD_NS = 4;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Legal ranges
    localparam logic [3:0] CH_MIN = 4'h1;
    localparam logic [3:0] CH_MAX = 4'ha;
    localparam logic [3:0] LIST_MIN = 4'h2;
    localparam logic [31:0] EXT_MIN = 32'h0000_0001;
    localparam logic [31:0] EXT_MAX = 32'h0000_0190;
    localparam logic [31:0] SETTLE_MAX = 32'h000f_423f;
    localparam logic [CHANNELS-1:0] CH_ONE = 10'h001;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_CHAN_CMD = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CHAN_STATE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_SCAN_LIST = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_EXT_COUNT = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_LIST_SEL = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_SETTLE = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_METHOD = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_VLIMIT = 8'h1c;
    localparam logic [ADDR_W-1:0] ADDR_SCAN_COUNT = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_INTERVAL = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_SCAN_CTRL = 8'h28;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h2c;
    localparam logic [ADDR_W-1:0] ADDR_STORE_IDX = 8'h30;

    // Channel command fields and opcodes
    localparam int CMD_CH_LSB = 0;
    localparam int CMD_OP_LSB = 8;
    localparam logic [1:0] OP_CLOSE = 2'h1;
    localparam logic [1:0] OP_OPEN = 2'h2;
    localparam logic [1:0] OP_OPEN_ALL = 2'h3;

    // Scan source select codes
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_INT = 2'h1;
    localparam logic [1:0] SEL_EXT = 2'h2;
    localparam logic [1:0] SEL_BAD = 2'h3;

    // Scan control bits
    localparam int CTRL_TIMER = 0;
    localparam int CTRL_STORE = 1;
    localparam int CTRL_ABORT = 2;
    localparam int CTRL_AGAIN = 3;
    localparam int CTRL_EXIT = 4;

    // Status bits
    localparam int ST_ACTIVE = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ABORTED = 2;
    localparam int ST_ERR_RANGE = 3;
    localparam int ST_ERR_HW = 4;
    localparam int ST_CARD = 5;

    // Reset values
    localparam logic [CHANNELS-1:0] LIST_RST = 10'h3ff;
    localparam logic [EXT_W-1:0] EXT_RST = 9'h001;
    localparam logic [CNT_W-1:0] COUNT_RST = 16'h000a;
    localparam logic [MS_W-1:0] INTERVAL_RST = 24'h0009c4;

    // Scan sequencer states
    typedef enum logic [2:0] {
        S_IDLE, S_GAP, S_CLOSE, S_SETTLE, S_READ, S_PACE, S_DONE
    } scan_state_type;
endpackage

// >>> logic/timer_if.sv
// Start and done handshake between the sequencer and the ms timer
`timescale 1ns/10ps
interface timer_if;
    logic start;
    logic [scan_pkg::MS_W-1:0] load_ms;
    logic done;
    modport ctrl (output start, output load_ms, input done);
    modport tmr (input start, input load_ms, output done);
endinterface

// >>> logic/ms_timer.sv
// Millisecond down-counter used for settling and scan pacing
`timescale 1ns/10ps
module ms_timer #(
    parameter int CYC_PER_MS = scan_pkg::CYC_PER_MS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Start and done
    timer_if.tmr tmr
);
    import scan_pkg::*;

    localparam int PRE_W = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_MS - 1);

    typedef struct packed {
        logic busy;
        logic done;
        logic [MS_W-1:0] left;
        logic [PRE_W-1:0] pre;
    } tmr_state_type;

    tmr_state_type q, d;

    if (CYC_PER_MS < 1) begin : g_bad_rate
        $error("CYC_PER_MS must be at least 1");
    end

    // A new start simply restarts the count, so no stale done can leak
    always_comb begin
        d = q;
        d.done = 1'b0;
        if (tmr.start) begin
            d.busy = 1'b1;
            d.left = tmr.load_ms;
            d.pre = '0;
        end else if (q.busy) begin
            if (q.left == '0) begin
                d.busy = 1'b0;
                d.done = 1'b1;
            end else if (q.pre == PRE_LAST) begin
                d.pre = '0;
                d.left = q.left - MS_W'(1);
            end else begin
                d.pre = q.pre + PRE_W'(1);
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tmr.done = q.done;
endmodule

// >>> tb/host_model.sv
// Host side APB master model for the relay scanner controller
`timescale 1ns/10ps
module host_model (
    // Clock
    input wire logic clk,
    // APB master side
    output logic [7:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus at time zero
    initial begin
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
    end

    // One transfer; held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        // Released lines show stale-inverted values, not the last ones
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// >>> tb/relay_scanner_command_control_tb_top.sv
// Self-checking bench for the relay scanner controller
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
    $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module relay_scanner_command_control_tb_top;
    import scan_pkg::*;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, card_present;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0] relay_close, short_en;
    logic [9:0] prev_q = 10'h000;
    logic vsrc_limit_200, scan_active, scan_done, read_take, store_take;
    logic [15:0] store_index;
    logic [9:0] got[$];
    int fails = 0, n_tests = 0, w, w1, n_store = 0;
    relay_scanner_command_control #(.CYC_PER_MS(4)) DUT (.clk(clk),
        .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .card_present(card_present),
        .relay_close(relay_close), .short_en(short_en),
        .vsrc_limit_200(vsrc_limit_200), .scan_active(scan_active),
        .scan_done(scan_done), .read_take(read_take),
        .store_take(store_take), .store_index(store_index));
    host_model host (.clk(clk), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // Record relays at each reading; flag make-before-break in scans
    always @(posedge clk) begin
        if (read_take === 1'b1) got.push_back(relay_close);
        if (store_take === 1'b1) n_store++;
        if (scan_active && prev_q != 0 && relay_close != 0)
            `CHK(relay_close, prev_q)
        prev_q <= relay_close;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic e);
        logic [31:0] q;
        logic r;
        host.xfer(1'b1, a, d, q, r);
        `CHK(r, e)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] x);
        logic [31:0] q;
        logic r;
        host.xfer(1'b0, a, 32'h0, q, r);
        `CHK(q & m, x)
    endtask
    function automatic logic [31:0] cmd(input logic [1:0] op, input int ch);
        return {22'h0, op, 4'h0, 4'(ch)};
    endfunction
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Clock at 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Watchdog well beyond the expected run
    initial begin
        #40000;
        fails++;
        complete_run;
    end
    // Main sequence
    initial begin
        reset_n = 1'b0;
        card_present = 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        `CHK(relay_close, 10'h000)
        wr(ADDR_SETTLE, 32'h2, 1'b1);
        wr(ADDR_METHOD, 32'h1, 1'b1);
        wr(ADDR_VLIMIT, 32'h1, 1'b1);
        wr(ADDR_LIST_SEL, 32'(SEL_INT), 1'b1);
        card_present <= 1'b1;
        repeat (4) @(posedge clk);
        wr(ADDR_CHAN_CMD, cmd(OP_CLOSE, 3), 1'b0);
        wr(ADDR_CHAN_CMD, cmd(OP_CLOSE, 7), 1'b0);
        rd(ADDR_CHAN_STATE, 32'h3ff, 32'h040);
        wr(ADDR_CHAN_CMD, cmd(OP_CLOSE, 0), 1'b1);
        wr(ADDR_CHAN_CMD, cmd(OP_CLOSE, 11), 1'b1);
        wr(ADDR_CHAN_CMD, cmd(OP_OPEN, 7), 1'b0);
        rd(ADDR_CHAN_STATE, 32'h3ff, 32'h0);
        wr(ADDR_CHAN_CMD, cmd(OP_CLOSE, 5), 1'b0);
        wr(ADDR_CHAN_CMD, cmd(OP_OPEN_ALL, 0), 1'b0);
        rd(ADDR_CHAN_STATE, 32'h3ff, 32'h0);
        wr(ADDR_SCAN_LIST, 32'h001, 1'b1);
        wr(ADDR_SCAN_LIST, 32'h015, 1'b0);
        rd(ADDR_SCAN_LIST, 32'hffff_ffff, 32'h015);
        wr(ADDR_EXT_COUNT, 32'd401, 1'b1);
        wr(ADDR_EXT_COUNT, 32'd400, 1'b0);
        rd(ADDR_EXT_COUNT, 32'hffff_ffff, 32'd400);
        wr(ADDR_SETTLE, 32'd1000000, 1'b1);
        wr(ADDR_SETTLE, 32'd2, 1'b0);
        rd(ADDR_SETTLE, 32'hffff_ffff, 32'd2);
        wr(ADDR_VLIMIT, 32'h1, 1'b0);
        wr(ADDR_METHOD, 32'h1, 1'b0);
        wr(ADDR_CHAN_CMD, cmd(OP_CLOSE, 3), 1'b0);
        @(negedge clk);
        `CHK(vsrc_limit_200, 1'b1)
        `CHK(short_en, 10'h3fb)
        wr(ADDR_METHOD, 32'h0, 1'b0);
        wr(ADDR_CHAN_CMD, cmd(OP_OPEN_ALL, 0), 1'b0);
        wr(ADDR_STATUS, 32'h1e, 1'b0);
        wr(ADDR_SCAN_COUNT, 32'd2, 1'b0);
        wr(ADDR_SCAN_CTRL, 32'h2, 1'b0);
        wr(ADDR_LIST_SEL, 32'(SEL_INT), 1'b0);
        w = 0;
        while (scan_done !== 1'b1 && w < 2000) begin
            @(posedge clk);
            w++;
        end
        @(negedge clk);
        `CHK(scan_done, 1'b1)
        `CHK(relay_close, 10'h000)
        `CHK(scan_active, 1'b0)
        `CHK(store_index, 16'd6)
        `CHK(32'(got.size()), 32'd6)
        `CHK(got[0], 10'h001)
        `CHK(got[1], 10'h004)
        `CHK(got[5], 10'h010)
        rd(ADDR_STATUS, 32'h3f, 32'h22);
        `CHK(n_store, 6)
        // Scan again with a 3 ms pause between the two passes
        wr(ADDR_INTERVAL, 32'd3, 1'b0);
        rd(ADDR_INTERVAL, 32'hffff_ffff, 32'd3);
        w1 = w;
        wr(ADDR_SCAN_CTRL, 32'h0b, 1'b0);
        @(negedge clk);
        w = 0;
        while (scan_done !== 1'b1 && w < 2000) begin
            @(posedge clk);
            w++;
        end
        `CHK(scan_done, 1'b1)
        `CHK(w - w1 >= 12, 1'b1)
        wr(ADDR_SCAN_CTRL, 32'h10, 1'b0);
        rd(ADDR_LIST_SEL, 32'h3, 32'h0);
        wr(ADDR_LIST_SEL, 32'(SEL_INT), 1'b0);
        repeat (10) @(posedge clk);
        wr(ADDR_SCAN_CTRL, 32'h06, 1'b0);
        @(negedge clk);
        `CHK(scan_active, 1'b0)
        `CHK(relay_close, 10'h000)
        rd(ADDR_STATUS, 32'h5, 32'h4);
        wr(ADDR_LIST_SEL, 32'(SEL_INT), 1'b0);
        repeat (10) @(posedge clk);
        wr(ADDR_LIST_SEL, 32'(SEL_NONE), 1'b0);
        @(negedge clk);
        `CHK(scan_active, 1'b0)
        rd(ADDR_LIST_SEL, 32'h3, 32'h0);
        complete_run;
    end
endmodule
